// [design/rec_pkg.sv]
// Package: constants, types and register map of the transfer record controller
// Overview of operation
// (RQ1) Stack-emulation bit set switches recording behaviour
// (RQ2) Calls recorded as in ordinary mode
// (RQ3) Return decrements pointer, then invalidates entry
// (RQ4) Popped entry becomes logical entry depth-1
// (RQ5) Swap overwrites entry 0, pointer unchanged
// (RQ6) Other transfer types suppressed in emulation
// (RQ7) Type filters and trap enables ignored
// (RQ8) Pop adds popped cycle field to tally
// (RQ9) Calls after a pop recorded cycle-invalid
// (RQ10) No records written while halted
// (RQ11) Halt set by hardware or software
// (RQ12) Overflow trap with enable sets halt
// (RQ13) Freezing overflow trap itself not recorded
// (RQ14) Overflow without trap never sets halt
// (RQ15) Breakpoint trap with enable halts, unrecorded
// (RQ16) Breakpoint is cause 3, not debug
// (RQ17) Guest traps use guest halt enables
// (RQ18) Custom extension active when custom bits nonzero
// (RQ19) Custom fields standard when bits zero
// (RQ20) Tally cleared on control write, clear
// (RQ21) Tally advances only while recording active
// (RQ22) Pointer wraps modulo buffer depth
package rec_pkg;
  localparam logic [11:0] ctl_lo_off    = 12'h000;
  localparam logic [11:0] ctl_hi_off    = 12'h004;
  localparam logic [11:0] vs_ctl_off    = 12'h008;
  localparam logic [11:0] status_off    = 12'h00c;
  localparam logic [11:0] clear_off     = 12'h010;
  localparam logic [11:0] tally_off     = 12'h014;
  localparam logic [11:0] entry_sel_off = 12'h018;
  localparam logic [11:0] entry_dat_off = 12'h01c;
  localparam logic [11:0] entry_tgt_off = 12'h020;
  // Control low word bits
  localparam int ctl_user_bit      = 0;
  localparam int ctl_super_bit     = 1;
  localparam int ctl_mach_bit      = 2;
  localparam int ctl_ext_trap_bit  = 3;
  localparam int ctl_stack_emu_bit = 7;
  localparam int ctl_ovf_frz_bit   = 11;
  localparam int ctl_bp_frz_bit    = 12;
  localparam int ctl_custom_lsb    = 24;
  localparam int ctl_custom_msb    = 27;
  // Status bits
  localparam int st_halted_bit     = 31;
  localparam int st_custom_bit     = 30;
  localparam logic [31:0] ctl_lo_reset = 32'h0000_0000;
  localparam logic [31:0] ctl_lo_mask  = 32'h0f00_189f;
  localparam logic [15:0] ctl_hi_reset = 16'h0000;
  localparam logic [3:0]  cause_breakpoint = 4'h3;
  localparam logic [31:0] tally_reset  = 32'h0000_0000;

  typedef enum logic [3:0] {
    xfer_none, xfer_ind_call, xfer_dir_call, xfer_ind_jump, xfer_dir_jump,
    xfer_swap, xfer_return, xfer_other_ind, xfer_other_dir, xfer_trap
  } xfer_kind_t;

  typedef enum logic [1:0] {priv_user, priv_super, priv_rsvd, priv_mach} priv_t;

  typedef struct packed {
    logic       valid;
    xfer_kind_t kind;
    logic [31:0] source;
    logic [31:0] target;
  } retire_t;

  typedef struct packed {
    logic       valid;
    logic       is_interrupt;
    logic       is_overflow;
    logic       is_debug;
    logic [3:0] cause;
    priv_t      dest_priv;
    logic       dest_virtual;
  } trap_t;

  typedef struct packed {
    logic        valid;
    logic        cycle_count_valid;
    logic [15:0] elapsed_cycle_field;
    logic [31:0] source;
  } entry_t;
endpackage : rec_pkg

// [design/transfer_record_ras_freeze.sv]
// Transfer record buffer controller with stack emulation and freeze
//
// The APB register port and the register offsets were decided locally.
module transfer_record_ras_freeze #(
  parameter int depth       = 16,
  parameter int tally_width = 27
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire rec_pkg::retire_t retire,
  input  wire rec_pkg::trap_t   trap,
  input  wire rec_pkg::priv_t   cur_priv,
  input  wire logic             cur_virtual,
  output logic                  halted,
  output logic [7:0]            write_pointer
);
  import rec_pkg::*;

  localparam int pw = $clog2(depth);

  // Pointer wrap relies on a power-of-two depth
  if (depth < 2 || depth > 256 || (depth & (depth - 1)) != 0)
  begin : g_bad_depth
    $error("depth must be a power of two from 2 to 256");
  end
  if (tally_width < 12 || tally_width > 32)
  begin : g_bad_tally
    $error("tally_width must be 12 to 32");
  end

  logic [31:0]          ctl_lo_reg;
  logic [15:0]          ctl_hi_reg;
  logic [31:0]          vs_ctl_reg;
  logic                 halted_reg;
  logic [pw-1:0]        buffer_write_pointer;
  logic [tally_width-1:0] elapsed_cycle_tally;
  logic                 tally_invalid_reg;
  logic                 popped_parent_reg;
  logic [pw-1:0]        sel_reg;
  entry_t               entry_mem [depth];
  logic [31:0]          target_mem [depth];

  // Saturating 16-bit cycle field: 12-bit mantissa, 4-bit exponent
  function automatic logic [15:0] encode_cycles(input logic [tally_width-1:0] t);
    logic [31:0] v;
    logic [15:0] r;
    int          msb;
    v   = 32'(t);
    r   = 16'h0000;
    msb = 0;
    for (int i = 0; i < 32; i++)
      if (v[i])
        msb = i;
    if (v < 32'h0000_1000)
      r = {4'h0, v[11:0]};
    else if (msb - 11 > 15)
      r = 16'hffff;
    else
      r = {4'(msb - 11), 12'(v >> (msb - 12))};
    return r;
  endfunction : encode_cycles

  function automatic logic [31:0] decode_cycles(input logic [15:0] f);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (f[15:12] == 4'h0)
      r = {20'h00000, f[11:0]};
    else
      r = (32'h0000_1000 + {20'h00000, f[11:0]}) << (f[15:12] - 4'h1);
    return r;
  endfunction : decode_cycles

  logic apb_write;
  logic apb_read;
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && penable && !pwrite;

  logic ctl_write;
  logic clear_write;
  logic halt_write;
  assign ctl_write   = apb_write && (paddr == ctl_lo_off || paddr == ctl_hi_off);
  assign clear_write = apb_write && paddr == clear_off;
  assign halt_write  = apb_write && paddr == status_off;

  // (RQ18) Custom extension active flag
  logic custom_active;
  assign custom_active = ctl_lo_reg[ctl_custom_msb:ctl_custom_lsb] != 4'h0;

  // (RQ1) Emulation mode select
  logic stack_emulation_enable;
  assign stack_emulation_enable = ctl_lo_reg[ctl_stack_emu_bit];

  logic priv_enabled;
  always_comb
  begin
    case (cur_priv)
      priv_user:  priv_enabled = ctl_lo_reg[ctl_user_bit];
      priv_super: priv_enabled = ctl_lo_reg[ctl_super_bit];
      priv_mach:  priv_enabled = ctl_lo_reg[ctl_mach_bit];
      default:    priv_enabled = 1'b0;
    endcase
  end

  // (RQ21) Active only when enabled and not halted
  logic active;
  assign active = priv_enabled && !halted_reg;

  // (RQ17) Guest traps use guest halt enables
  logic halt_on_counter_overflow;
  logic halt_on_breakpoint;
  assign halt_on_counter_overflow = trap.dest_virtual ? vs_ctl_reg[ctl_ovf_frz_bit]
                                                      : ctl_lo_reg[ctl_ovf_frz_bit];
  assign halt_on_breakpoint = trap.dest_virtual ? vs_ctl_reg[ctl_bp_frz_bit]
                                                : ctl_lo_reg[ctl_bp_frz_bit];

  // (RQ12) Overflow trap to M or S mode; (RQ14) only a real trap counts
  logic freeze_ovf;
  assign freeze_ovf = trap.valid && trap.is_interrupt && trap.is_overflow &&
                      halt_on_counter_overflow &&
                      (trap.dest_priv == priv_mach || trap.dest_priv == priv_super);
  // (RQ16) Breakpoint is synchronous cause 3, debug entry excluded
  logic freeze_bp;
  assign freeze_bp = trap.valid && !trap.is_interrupt && !trap.is_debug &&
                     trap.cause == cause_breakpoint && halt_on_breakpoint &&
                     (trap.dest_priv == priv_mach || trap.dest_priv == priv_super);
  logic freeze_event;
  assign freeze_event = freeze_ovf || freeze_bp;

  // Ordinary-mode filter on the high control word: one bit per transfer kind
  logic kind_allowed;
  always_comb
  begin
    kind_allowed = !ctl_hi_reg[retire.kind];
  end

  // (RQ10) Halted blocks all writes; (RQ13) (RQ15) freezing trap unrecorded
  logic do_call;
  logic do_ret;
  logic do_swap;
  logic do_plain;
  logic do_trap;
  always_comb
  begin
    do_call  = 1'b0;
    do_ret   = 1'b0;
    do_swap  = 1'b0;
    do_plain = 1'b0;
    do_trap  = 1'b0;
    if (active && !ctl_write && !clear_write)
    begin
      if (stack_emulation_enable)
      begin
        // (RQ2) (RQ6) (RQ7) Only calls, returns and swaps; filters ignored
        if (retire.valid && (retire.kind == xfer_ind_call || retire.kind == xfer_dir_call))
          do_call = 1'b1;
        else if (retire.valid && retire.kind == xfer_return)
          do_ret = 1'b1;
        else if (retire.valid && retire.kind == xfer_swap)
          do_swap = 1'b1;
      end
      else
      begin
        if (retire.valid && retire.kind != xfer_none && kind_allowed)
          do_plain = 1'b1;
        else if (trap.valid && !freeze_event && ctl_lo_reg[ctl_ext_trap_bit])
          do_trap = 1'b1;
      end
    end
  end

  logic [pw-1:0] ptr_dec;
  logic [pw-1:0] ptr_top;
  // (RQ22) Wrap modulo depth both ways
  assign ptr_dec = buffer_write_pointer - pw'(1);
  assign ptr_top = buffer_write_pointer - pw'(1);

  logic [15:0] cur_field;
  logic        cur_ccv;
  assign cur_field = encode_cycles(elapsed_cycle_tally);
  // (RQ9) Calls after a popped parent recorded cycle-invalid
  assign cur_ccv   = !tally_invalid_reg && !(stack_emulation_enable && popped_parent_reg);

  // (RQ11) Halt: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted_reg <= 1'b0;
    else if (freeze_event)
      halted_reg <= 1'b1;
    else if (halt_write)
      halted_reg <= pwdata[st_halted_bit];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_lo_reg <= ctl_lo_reset;
      ctl_hi_reg <= ctl_hi_reset;
      vs_ctl_reg <= ctl_lo_reset;
    end
    else if (apb_write && paddr == ctl_lo_off)
      ctl_lo_reg <= pwdata & ctl_lo_mask;
    else if (apb_write && paddr == ctl_hi_off)
      ctl_hi_reg <= pwdata[15:0];
    else if (apb_write && paddr == vs_ctl_off)
      vs_ctl_reg <= pwdata & ctl_lo_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buffer_write_pointer <= '0;
    else if (clear_write)
      buffer_write_pointer <= '0;
    // (RQ3) Return decrements the pointer
    else if (do_ret)
      buffer_write_pointer <= ptr_dec;
    // (RQ5) Swap leaves pointer alone; (RQ22) increment wraps
    else if (do_call || do_plain || do_trap)
      buffer_write_pointer <= buffer_write_pointer + pw'(1);
  end

  // (RQ20) Tally cleared on control write or buffer clear
  logic [31:0] tally_sum;
  logic [31:0] popped_cycles;
  // An invalid slot holds no count, so popping it adds nothing
  assign popped_cycles = entry_mem[ptr_dec].valid ?
                         decode_cycles(entry_mem[ptr_dec].elapsed_cycle_field) : 32'h0000_0000;
  assign tally_sum = 32'(elapsed_cycle_tally) + popped_cycles;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      elapsed_cycle_tally <= '0;
      tally_invalid_reg   <= 1'b1;
    end
    else if (ctl_write || clear_write)
    begin
      elapsed_cycle_tally <= '0;
      tally_invalid_reg   <= 1'b1;
    end
    else if (do_call || do_plain || do_trap || do_swap)
    begin
      elapsed_cycle_tally <= '0;
      tally_invalid_reg   <= !active;
    end
    // (RQ8) Pop adds the popped entry's cycle field
    else if (do_ret)
    begin
      if (tally_sum > 32'({tally_width{1'b1}}))
        elapsed_cycle_tally <= '1;
      else
        elapsed_cycle_tally <= tally_sum[tally_width-1:0];
    end
    // (RQ21) Count only active cycles, saturating
    else if (active && elapsed_cycle_tally != '1)
      elapsed_cycle_tally <= elapsed_cycle_tally + tally_width'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      popped_parent_reg <= 1'b0;
    else if (ctl_write || clear_write || do_call || do_plain)
      popped_parent_reg <= 1'b0;
    else if (do_ret)
      popped_parent_reg <= 1'b1;
  end

  entry_t new_entry;
  always_comb
  begin
    new_entry.valid               = 1'b1;
    new_entry.cycle_count_valid   = cur_ccv;
    new_entry.elapsed_cycle_field = cur_field;
    new_entry.source              = retire.source;
  end

  // Entries have no reset; validity alone is cleared, by buffer clear or by a pop
  always_ff @(posedge pclk)
  begin
    for (int i = 0; i < depth; i++)
    begin
      if (clear_write)
        entry_mem[i].valid <= 1'b0;
      // (RQ3) (RQ4) Invalidate the popped slot, now logical depth-1
      else if (do_ret && pw'(i) == ptr_dec)
        entry_mem[i].valid <= 1'b0;
      // (RQ5) Swap overwrites logical entry 0
      else if (do_swap && pw'(i) == ptr_top)
      begin
        entry_mem[i] <= new_entry;
        target_mem[i] <= retire.target;
      end
      else if ((do_call || do_plain || do_trap) && pw'(i) == buffer_write_pointer)
      begin
        entry_mem[i] <= new_entry;
        target_mem[i] <= retire.target;
      end
    end
  end

  // Register file readback, selected logical entry counted from the newest
  logic [pw-1:0] rd_phys;
  assign rd_phys = buffer_write_pointer - pw'(1) - sel_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_reg <= '0;
    else if (apb_write && paddr == entry_sel_off)
      sel_reg <= pwdata[pw-1:0];
  end

  logic [31:0] rd_value;
  logic        rd_err;
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_err   = 1'b0;
    if (paddr == ctl_lo_off)
      rd_value = ctl_lo_reg;
    else if (paddr == ctl_hi_off)
      rd_value = {16'h0000, ctl_hi_reg};
    else if (paddr == vs_ctl_off)
      rd_value = vs_ctl_reg;
    else if (paddr == status_off)
      // (RQ19) Custom status bit reads zero without the extension
      rd_value = {halted_reg, custom_active & popped_parent_reg, 22'h000000,
                  8'(buffer_write_pointer)};
    else if (paddr == clear_off)
      rd_value = 32'h0000_0000;
    else if (paddr == tally_off)
      rd_value = 32'(elapsed_cycle_tally);
    else if (paddr == entry_sel_off)
      rd_value = 32'(sel_reg);
    else if (paddr == entry_dat_off)
      rd_value = {entry_mem[rd_phys].valid, entry_mem[rd_phys].cycle_count_valid,
                  14'h0000, entry_mem[rd_phys].elapsed_cycle_field};
    else if (paddr == entry_tgt_off)
      rd_value = entry_mem[rd_phys].valid ? entry_mem[rd_phys].source : 32'h0000_0000;
    else
      rd_err = 1'b1;
  end

  // Zero-wait slave: pready is registered high one cycle into each access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (psel && !penable && !pwrite)
        prdata <= rd_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halted        <= 1'b0;
      write_pointer <= 8'h00;
    end
    else
    begin
      halted        <= halted_reg;
      write_pointer <= 8'(buffer_write_pointer);
    end
  end

  logic unused_read;
  assign unused_read = apb_read;
endmodule : transfer_record_ras_freeze

// [verification/rec_asserts.sv]
// Assertion checker for the transfer record controller ports
module rec_asserts #(
  parameter int depth       = 16,
  parameter int tally_width = 27
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire rec_pkg::retire_t retire,
  input wire rec_pkg::trap_t   trap,
  input wire rec_pkg::priv_t   cur_priv,
  input wire logic             cur_virtual,
  input wire logic             halted,
  input wire logic [7:0]       write_pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  import rec_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic swr;
  // Software write of the status word can move the halt flag
  assign swr = psel && penable && pwrite && paddr == status_off;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_frozen_idle;
    halted && !psel;
  endsequence
  AST_ZERO_WAIT: assert property (s_setup |=> pready)
    else $error("no answer in access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("answer outside access cycle");
  AST_UNMAPPED_ERR: assert property (pready && paddr > entry_tgt_off |-> pslverr)
    else $error("unmapped address not refused");
  AST_MAPPED_OK: assert property (pready && paddr <= entry_tgt_off && paddr[1:0] == 2'b00
    |-> !pslverr)
    else $error("mapped address refused");
  AST_REFUSED_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  AST_HALT_STICKY: assert property (!swr ##1 (halted && !swr) |=> halted)
    else $error("halt dropped without software write");
  AST_HALT_CAUSE: assert property ($rose(halted) |-> $past(swr, 2) || $past(swr, 3)
    || $past(trap.valid, 2) || $past(trap.valid, 3) || $past(trap.valid, 4))
    else $error("halt rose without trap or write");
  AST_FROZEN_POINTER: assert property (s_frozen_idle ##1 s_frozen_idle |=>
    $stable(write_pointer))
    else $error("pointer moved while halted");
  AST_QUIET_POINTER: assert property (!retire.valid && !trap.valid && !psel
    |-> ##2 $stable(write_pointer))
    else $error("pointer moved with no transfer");
endmodule : rec_asserts

// [verification/core_model.sv]
// Retirement and trap source standing in for the processor core
module core_model (
  input  wire logic        pclk,
  output rec_pkg::retire_t retire,
  output rec_pkg::trap_t   trap,
  output rec_pkg::priv_t   cur_priv,
  output logic             cur_virtual
);
  timeunit 1ns;
  timeprecision 1ps;
  import rec_pkg::*;
  initial
  begin
    retire = '0;
    trap = '0;
    cur_priv = priv_mach;
    cur_virtual = 1'b0;
  end
  // One retired transfer, presented for a single edge
  task automatic xfer(input xfer_kind_t k);
    retire <= '{1'b1, k, 32'h0000_1000, 32'h0000_2000};
    @(posedge pclk);
    retire.valid <= 1'b0;
    // Idle source is poisoned to 32'hffff_efff so stale values are never mistaken for live ones
    retire.source <= 32'hffff_efff;
    // Idle edge, so a following call never re-drives in this step
    @(posedge pclk);
  endtask : xfer
  task automatic raise(input logic intr, ovf, dbg, input logic [3:0] c, input priv_t p,
                       input logic v);
    trap <= '{1'b1, intr, ovf, dbg, c, p, v};
    @(posedge pclk);
    trap.valid <= 1'b0;
    @(posedge pclk);
  endtask : raise
endmodule : core_model

// [verification/tb.sv]
// Self-checking testbench for the transfer record controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rec_pkg::*;
  localparam int depth = 16;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, halted, err;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, t1;
  logic [7:0]       write_pointer;
  retire_t          retire;
  trap_t            trap;
  priv_t            cur_priv;
  logic             cur_virtual;
  int               errors, n_compared;
  transfer_record_ras_freeze #(.depth(depth), .tally_width(27)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .retire(retire), .trap(trap), .cur_priv(cur_priv), .cur_virtual(cur_virtual),
    .halted(halted), .write_pointer(write_pointer));
  core_model core (.pclk(pclk), .retire(retire), .trap(trap), .cur_priv(cur_priv),
    .cur_virtual(cur_virtual));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic finish_test(input bit timed_out);
    if (timed_out)
      errors++;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      finish_test(1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd & m, exp);
  endtask : rdchk
  // Pointer output trails the recording edge by one cycle
  task automatic pchk(input logic [7:0] exp);
    repeat (2) @(posedge pclk);
    check("pointer", write_pointer, exp);
  endtask : pchk
  task automatic hwait(input logic exp);
    for (int n = 0; n < 10 && halted !== exp; n++)
      @(posedge pclk);
    check("halted", halted, exp);
    if (halted !== exp)
      finish_test(1);
  endtask : hwait
  task automatic t_regs();
    rdchk("control", ctl_lo_off, 32'hffff_ffff, ctl_lo_reset);
    rdchk("status", status_off, 32'hffff_ffff, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check("slverr", err, 32'h1);
    apb(1'b1, ctl_lo_off, 32'hffff_ffff);
    rdchk("control mask", ctl_lo_off, 32'hffff_ffff, ctl_lo_mask);
  endtask : t_regs
  task automatic t_stack();
    apb(1'b1, clear_off, 32'h0);
    apb(1'b1, ctl_hi_off, 32'h0000_ffff);
    apb(1'b1, ctl_lo_off, 32'h0000_008c);
    core.xfer(xfer_dir_call);
    core.xfer(xfer_ind_call);
    pchk(8'h02);
    core.xfer(xfer_dir_jump);
    core.xfer(xfer_other_ind);
    core.xfer(xfer_trap);
    core.raise(1'b0, 1'b0, 1'b0, 4'h5, priv_mach, 1'b0);
    pchk(8'h02);
    core.xfer(xfer_return);
    pchk(8'h01);
    apb(1'b1, entry_sel_off, 32'(depth - 1));
    rdchk("popped valid", entry_dat_off, 32'h8000_0000, 32'h0);
    core.xfer(xfer_swap);
    pchk(8'h01);
    apb(1'b1, entry_sel_off, 32'h0);
    rdchk("swap valid", entry_dat_off, 32'h8000_0000, 32'h8000_0000);
    core.xfer(xfer_return);
    core.xfer(xfer_return);
    pchk(8'(depth - 1));
    rdchk("custom off", status_off, 32'h4000_0000, 32'h0);
    core.xfer(xfer_dir_call);
    pchk(8'h00);
    rdchk("ccv", entry_dat_off, 32'h4000_0000, 32'h0);
    apb(1'b1, ctl_lo_off, 32'h0100_008c);
    core.xfer(xfer_return);
    rdchk("custom flag", status_off, 32'h4000_0000, 32'h4000_0000);
  endtask : t_stack
  task automatic t_freeze();
    apb(1'b1, clear_off, 32'h0);
    apb(1'b1, ctl_hi_off, 32'h0);
    apb(1'b1, ctl_lo_off, 32'h0000_180c);
    core.xfer(xfer_dir_jump);
    pchk(8'h01);
    repeat (40) @(posedge pclk);
    apb(1'b0, tally_off, 32'h0);
    check("tally runs", rd >= 32'd40, 32'h1);
    apb(1'b1, ctl_hi_off, 32'h0);
    apb(1'b0, tally_off, 32'h0);
    check("tally cleared", rd < 32'd8, 32'h1);
    core.raise(1'b1, 1'b1, 1'b0, 4'h0, priv_mach, 1'b0);
    hwait(1'b1);
    pchk(8'h01);
    core.xfer(xfer_dir_call);
    pchk(8'h01);
    apb(1'b0, tally_off, 32'h0);
    t1 = rd;
    repeat (10) @(posedge pclk);
    rdchk("tally frozen", tally_off, 32'hffff_ffff, t1);
    apb(1'b1, status_off, 32'h0);
    hwait(1'b0);
    core.raise(1'b0, 1'b0, 1'b0, cause_breakpoint, priv_super, 1'b0);
    hwait(1'b1);
    pchk(8'h01);
    apb(1'b1, status_off, 32'h0);
    hwait(1'b0);
    core.raise(1'b0, 1'b0, 1'b1, cause_breakpoint, priv_mach, 1'b0);
    repeat (4) @(posedge pclk);
    check("debug no halt", halted, 32'h0);
    apb(1'b1, ctl_lo_off, 32'h0000_000c);
    apb(1'b1, vs_ctl_off, 32'h0000_1000);
    core.raise(1'b0, 1'b0, 1'b0, cause_breakpoint, priv_mach, 1'b0);
    repeat (4) @(posedge pclk);
    check("disabled no halt", halted, 32'h0);
    core.raise(1'b0, 1'b0, 1'b0, cause_breakpoint, priv_super, 1'b1);
    hwait(1'b1);
    apb(1'b1, status_off, 32'h0);
    hwait(1'b0);
    apb(1'b1, status_off, 32'h8000_0000);
    hwait(1'b1);
  endtask : t_freeze
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stack();
    t_freeze();
    finish_test(0);
  end
endmodule : tb
bind transfer_record_ras_freeze rec_asserts #(.depth(depth), .tally_width(tally_width)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .retire(retire), .trap(trap), .cur_priv(cur_priv), .cur_virtual(cur_virtual),
  .halted(halted), .write_pointer(write_pointer));
